// file: logic/psbc_device.sv
// Monitor device: status flags, fault/alert chain, balance safety timer
module psbc_device
   import psbc_pkg::*;
#(
   parameter int OT_HOLD = OT_HOLD_CYC,
   parameter int TICK_CYC = SEC_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // Host side
   psbc_if.device LNK,
   // Strap and chain
   input wire logic HOST_SEL,
   input wire logic FAULT_NORTH,
   input wire logic ALERT_NORTH,
   output logic FAULT_SOUTH,
   output logic ALERT_SOUTH,
   // Event inputs
   input wire logic CFG_DBL_ERR,
   input wire logic CRC_ERR,
   input wire logic CELL_UNDERVOLT_FLAG,
   input wire logic CELL_OVERVOLT_FLAG,
   input wire logic [5:0] DEV_ADDR,
   input wire logic PARITY_ERR,
   input wire logic CFG_MEM_CORRECTED_FLAG,
   input wire logic DIE_OVERHEAT_FLAG,
   input wire logic SLEEP_EN,
   input wire logic TEMP_INPUT_ONE_OVER,
   input wire logic TEMP_INPUT_TWO_OVER,
   // Analog controls
   output logic THERMISTOR_ONE_POWER_EN,
   output logic THERMISTOR_TWO_POWER_EN,
   output logic OT_COMP_EN,
   output logic [CELLS-1:0] BALANCE_OUTPUT
);
   // ***************************
   // State
   // ***************************
   typedef struct packed {
      logic por;
      logic sleep;
      logic [31:0] ot_cnt;
      logic [FAULT_W-1:0] fault;
      logic [ALERT_W-1:0] alert;
      logic [1:0] tsen;
      logic [7:0] bal;
      logic [TIMER_W-1:0] tval;
      logic run;
      logic [31:0] pre;
      logic [5:0] mins;
      logic [TIMER_W-1:0] left;
      logic fs;
      logic as;
      logic fh;
      logic ah;
      logic ote;
      logic [CELLS-1:0] bo;
   } psbc_dev_t;
   psbc_dev_t s_q, s_d;
   logic [ALERT_W-1:0] a_ev;
   logic [FAULT_W-1:0] f_ev;
   logic tick;
   logic fo;
   logic ao;

   function automatic logic [7:0] w1c(logic [7:0] cur, logic [7:0] ev,
      logic [7:0] wd, logic wr, int fb);
      logic [7:0] r;
      r = cur;
      if (wr) begin
         r = cur & ~wd;
         r[fb] = wd[fb];
      end
      return r | ev; // Set beats clear
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.por = 1'b0;
      s_d.sleep = SLEEP_EN;
      f_ev = '0;
      f_ev[F_CFG_DBL] = CFG_DBL_ERR;
      f_ev[F_POR] = s_q.por;
      f_ev[F_CRC] = CRC_ERR;
      f_ev[F_UV] = CELL_UNDERVOLT_FLAG;
      f_ev[F_OV] = CELL_OVERVOLT_FLAG;
      a_ev = '0;
      a_ev[A_ADDR] = (DEV_ADDR < ADDR_MIN) || (DEV_ADDR > ADDR_MAX);
      a_ev[A_PARITY] = PARITY_ERR;
      a_ev[A_CFG_COR] = CFG_MEM_CORRECTED_FLAG;
      a_ev[A_OVERHEAT] = DIE_OVERHEAT_FLAG;
      a_ev[A_SLEEP] = SLEEP_EN ^ s_q.sleep;
      // Comparator outputs ignored while settling
      a_ev[A_OT1] = TEMP_INPUT_ONE_OVER && s_q.ot_cnt == 0 && !SLEEP_EN;
      a_ev[A_OT2] = TEMP_INPUT_TWO_OVER && s_q.ot_cnt == 0 && !SLEEP_EN;
      s_d.fault = FAULT_W'(w1c({2'h0, s_q.fault}, {2'h0, f_ev},
         LNK.wdata, LNK.wr_fault, F_FORCE));
      s_d.alert = w1c(s_q.alert, a_ev, LNK.wdata, LNK.wr_alert, A_FORCE);
      if (LNK.wr_tsen) begin
         s_d.tsen = LNK.wdata[1:0];
      end
      // Settle hold after sleep exit
      if (s_q.sleep && !SLEEP_EN) begin
         s_d.ot_cnt = OT_HOLD;
      end else if (s_q.ot_cnt != 0) begin
         s_d.ot_cnt = s_q.ot_cnt - 32'h1;
      end
      // Prescaler; minutes use sixty second ticks
      tick = 1'b0;
      if (s_q.run) begin
         if (s_q.pre >= TICK_CYC - 1) begin
            s_d.pre = '0;
            if (!s_q.bal[BAL_RANGE_BIT] ||
               s_q.mins == 6'(SEC_PER_MIN - 1)) begin
               s_d.mins = '0;
               tick = 1'b1;
            end else begin
               s_d.mins = s_q.mins + 6'h1;
            end
         end else begin
            s_d.pre = s_q.pre + 32'h1;
         end
      end
      if (tick) begin
         s_d.left = s_q.left - 8'h1;
         if (s_q.left <= 8'h1) begin
            s_d.run = 1'b0;
            s_d.bal[CELLS-1:0] = '0;
         end
      end
      if (LNK.wr_time) begin
         s_d.tval = LNK.wdata;
      end
      if (LNK.wr_bal) begin
         s_d.bal = LNK.wdata;
         if (LNK.wdata[CELLS-1:0] == '0) begin
            s_d.run = 1'b0;
         end else if (s_q.bal[CELLS-1:0] == '0) begin
            // Only a zero start restarts
            s_d.pre = '0;
            s_d.mins = '0;
            s_d.left = LNK.wr_time ? LNK.wdata : s_q.tval;
            // Zero period never runs, else it would wrap
            s_d.run = (s_d.left != '0);
         end
      end
      if (!s_d.run) begin
         s_d.pre = '0;
         s_d.mins = '0;
      end
      // Chain: force and pin events except the CRC flag, plus north relay
      fo = FAULT_NORTH || (|(s_q.fault & ~(6'h1 << F_CRC)));
      ao = ALERT_NORTH || (|s_q.alert);
      s_d.fs = fo && HOST_SEL;
      s_d.fh = fo && !HOST_SEL;
      s_d.as = ao && HOST_SEL;
      s_d.ah = ao && !HOST_SEL;
      s_d.ote = (s_d.ot_cnt == 0) && !s_d.sleep;
      // Zero timer value blocks balancing
      s_d.bo = (s_d.run && s_d.tval != 0) ? s_d.bal[CELLS-1:0] : '0;
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '0;
         s_q.por <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************
   // Outputs
   // ***************************
   assign THERMISTOR_ONE_POWER_EN = s_q.tsen[0];
   assign THERMISTOR_TWO_POWER_EN = s_q.tsen[1];
   assign OT_COMP_EN = s_q.ote;
   assign BALANCE_OUTPUT = s_q.bo;
   assign FAULT_SOUTH = s_q.fs;
   assign ALERT_SOUTH = s_q.as;
   assign LNK.fault_h = s_q.fh;
   assign LNK.alert_h = s_q.ah;
   assign LNK.fault_status = s_q.fault;
   assign LNK.alert_status = s_q.alert;
   assign LNK.dev_status = {5'h0, s_q.run, |s_q.alert, |s_q.fault};
endmodule // psbc_device

// file: logic/psbc_host.sv
// Host controller: AXI4-Lite command registers driving the device link
module psbc_host
   import psbc_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // Device side
   psbc_if.host LNK,
   // AXI4-Lite slave
   input wire logic [7:0] S_AWADDR,
   input wire logic S_AWVALID,
   output logic S_AWREADY,
   input wire logic [31:0] S_WDATA,
   input wire logic [3:0] S_WSTRB,
   input wire logic S_WVALID,
   output logic S_WREADY,
   output logic [1:0] S_BRESP,
   output logic S_BVALID,
   input wire logic S_BREADY,
   input wire logic [7:0] S_ARADDR,
   input wire logic S_ARVALID,
   output logic S_ARREADY,
   output logic [31:0] S_RDATA,
   output logic [1:0] S_RRESP,
   output logic S_RVALID,
   input wire logic S_RREADY
);
   // Register word offsets, write side strobes one link command
   localparam logic [7:0] R_FAULT = 8'h00;
   localparam logic [7:0] R_ALERT = 8'h04;
   localparam logic [7:0] R_BAL = 8'h08;
   localparam logic [7:0] R_TIME = 8'h0C;
   localparam logic [7:0] R_TSEN = 8'h10;
   localparam logic [7:0] R_DEV = 8'h14;
   typedef struct packed {
      logic aw;
      logic [7:0] awa;
      logic w;
      logic [7:0] wd;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
      logic [4:0] stb;
   } psbc_host_t;
   psbc_host_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.stb = '0;
      if (S_AWVALID && !s_q.aw && !s_q.bv) begin
         s_d.aw = 1'b1;
         s_d.awa = S_AWADDR;
      end
      if (S_WVALID && !s_q.w && !s_q.bv) begin
         s_d.w = 1'b1;
         s_d.wd = S_WDATA[7:0];
      end
      if (s_q.aw && s_q.w) begin
         // Write-one-clear goes straight through
         case (s_q.awa)
            R_FAULT: s_d.stb[0] = 1'b1;
            R_ALERT: s_d.stb[1] = 1'b1;
            R_BAL: s_d.stb[2] = 1'b1;
            R_TIME: s_d.stb[3] = 1'b1;
            R_TSEN: s_d.stb[4] = 1'b1;
            default: ;
         endcase
         s_d.aw = 1'b0;
         s_d.w = 1'b0;
         s_d.bv = 1'b1;
         s_d.br = (s_d.stb != 0) ? 2'h0 : 2'h2;
      end else if (s_q.bv && S_BREADY) begin
         s_d.bv = 1'b0;
      end
      if (S_ARVALID && !s_q.rv) begin
         s_d.rv = 1'b1;
         s_d.rr = 2'h0;
         case (S_ARADDR)
            R_FAULT: s_d.rd = {26'h0, LNK.fault_status};
            R_ALERT: s_d.rd = {24'h0, LNK.alert_status};
            R_DEV: s_d.rd = {22'h0, LNK.alert_h, LNK.fault_h,
               LNK.dev_status};
            default: begin
               s_d.rd = '0;
               s_d.rr = 2'h2;
            end
         endcase
      end else if (s_q.rv && S_RREADY) begin
         s_d.rv = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign S_AWREADY = !s_q.aw && !s_q.bv;
   assign S_WREADY = !s_q.w && !s_q.bv;
   assign S_BVALID = s_q.bv;
   assign S_BRESP = s_q.br;
   assign S_ARREADY = !s_q.rv;
   assign S_RVALID = s_q.rv;
   assign S_RDATA = s_q.rd;
   assign S_RRESP = s_q.rr;
   assign LNK.wr_fault = s_q.stb[0];
   assign LNK.wr_alert = s_q.stb[1];
   assign LNK.wr_bal = s_q.stb[2];
   assign LNK.wr_time = s_q.stb[3];
   assign LNK.wr_tsen = s_q.stb[4];
   assign LNK.wdata = s_q.wd;
endmodule // psbc_host

// file: pkg/psbc_if.sv
// Interface joining the monitor device and its host-side controller
interface psbc_if;
   import psbc_pkg::*;
   logic fault_h;
   logic alert_h;
   logic wr_fault;
   logic wr_alert;
   logic wr_bal;
   logic wr_time;
   logic wr_tsen;
   logic [7:0] wdata;
   logic [FAULT_W-1:0] fault_status;
   logic [ALERT_W-1:0] alert_status;
   logic [7:0] dev_status;
   modport device (output fault_h, alert_h, fault_status, alert_status,
      dev_status, input wr_fault, wr_alert, wr_bal, wr_time, wr_tsen,
      wdata);
   modport host (input fault_h, alert_h, fault_status, alert_status,
      dev_status, output wr_fault, wr_alert, wr_bal, wr_time, wr_tsen,
      wdata);
endinterface

// file: pkg/psbc_pkg.sv
// Package of constants for the protector status and balance control link
package psbc_pkg;
   // ***************************
   // Clock and timing
   // ***************************
   localparam int CLK_HZ = 20000000;
   localparam int OT_HOLD_US = 200;
   localparam int OT_HOLD_CYC = (OT_HOLD_US * (CLK_HZ / 1000000));
   localparam int SEC_CYC = CLK_HZ;
   localparam int SEC_PER_MIN = 60;
   // ***************************
   // Field layout
   // ***************************
   localparam int CELLS = 6;
   localparam int BAL_RANGE_BIT = 7;
   localparam int TIMER_W = 8;
   // Fault status bits
   localparam int F_CFG_DBL = 0;
   localparam int F_FORCE = 1;
   localparam int F_POR = 2;
   localparam int F_CRC = 3;
   localparam int F_UV = 4;
   localparam int F_OV = 5;
   localparam int FAULT_W = 6;
   // Alert status bits
   localparam int A_ADDR = 0;
   localparam int A_PARITY = 1;
   localparam int A_CFG_COR = 2;
   localparam int A_FORCE = 3;
   localparam int A_OVERHEAT = 4;
   localparam int A_SLEEP = 5;
   localparam int A_OT1 = 6;
   localparam int A_OT2 = 7;
   localparam int ALERT_W = 8;
   localparam logic [5:0] ADDR_MIN = 6'h01;
   localparam logic [5:0] ADDR_MAX = 6'h3E;
endpackage

// file: test/psbc_properties.sv
// Checker of status flags and chain pins on the device link
module psbc_properties
   import psbc_pkg::*;
(
   // Clock, reset and strap
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic HOST_SEL,
   // Link signals
   input wire logic fault_h,
   input wire logic alert_h,
   input wire logic wr_fault,
   input wire logic wr_alert,
   input wire logic [7:0] wdata,
   input wire logic [FAULT_W-1:0] fault_status,
   input wire logic [ALERT_W-1:0] alert_status,
   input wire logic [7:0] dev_status
);
   // ***************
   // Properties
   // ***************
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   property p_fagg; |fault_status |-> ##[0:1] dev_status[0]; endproperty
   a_fagg: assert property (p_fagg) else $error("fault sum low");
   property p_aagg; |alert_status |-> ##[0:1] dev_status[1]; endproperty
   a_aagg: assert property (p_aagg) else $error("alert sum low");
   // Mask 6'h37 leaves out the CRC flag, which never reaches a pin
   property p_fpin;
      !HOST_SEL && |(fault_status & 6'h37) |-> ##[0:2] fault_h;
   endproperty
   a_fpin: assert property (p_fpin) else $error("fault pin low");
   property p_apin; !HOST_SEL && |alert_status |-> ##[0:2] alert_h; endproperty
   a_apin: assert property (p_apin) else $error("alert pin low");
   property p_hold;
      fault_status[F_POR] && !(wr_fault && wdata[F_POR]) |=>
         fault_status[F_POR];
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_w1c; wr_fault && wdata[F_POR] |=> !fault_status[F_POR]; endproperty
   a_w1c: assert property (p_w1c) else $error("flag kept");
   property p_ff;
      wr_fault |=> fault_status[F_FORCE] == $past(wdata[F_FORCE]);
   endproperty
   a_ff: assert property (p_ff) else $error("fault force wrong");
   property p_af;
      wr_alert |=> alert_status[A_FORCE] == $past(wdata[A_FORCE]);
   endproperty
   a_af: assert property (p_af) else $error("alert force wrong");
   property p_ro; !wr_alert |=> $stable(alert_status[A_FORCE]); endproperty
   a_ro: assert property (p_ro) else $error("force moved");
   c_bal: cover property (dev_status[2]);
   c_fh: cover property (fault_h);
   c_ff: cover property (wr_fault && wdata[F_FORCE]);
endmodule // psbc_properties

// file: test/tb.sv
// Self-checking bench for the device and host controller pair
module tb
   import psbc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   // ***************
   // Set-up
   // ***************
   // Short counts keep timer runs to at most about 1200 cycles
   localparam int TICK = 10;
   localparam int HOLD = 10;
   localparam int EVB[10] = '{F_CFG_DBL, F_CRC, F_UV, F_OV, A_PARITY,
      A_CFG_COR, A_OVERHEAT, A_OT1, A_OT2, A_ADDR};
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, fn = 1'b0, an = 1'b0;
   logic slp = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0;
   logic r_r = 1'b0;
   logic sf, sa, t1, t2, ote, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic [9:0] ev = '0;
   logic [7:0] aw_a = '0, ar_a = '0;
   logic [5:0] bal;
   logic [31:0] w_d = '0, r_d, d;
   int num_errors = 0, tests_run = 0, n;
   psbc_if lnk ();
   psbc_device #(.OT_HOLD(HOLD), .TICK_CYC(TICK)) i_psbc_device (
      .REF_CLK(clk), .RESET_N(rst_n), .LNK(lnk), .HOST_SEL(hsel),
      .FAULT_NORTH(fn), .ALERT_NORTH(an), .FAULT_SOUTH(sf),
      .ALERT_SOUTH(sa), .CFG_DBL_ERR(ev[0]), .CRC_ERR(ev[1]),
      .CELL_UNDERVOLT_FLAG(ev[2]), .CELL_OVERVOLT_FLAG(ev[3]),
      .DEV_ADDR(ev[9] ? 6'h00 : 6'h05), .PARITY_ERR(ev[4]),
      .CFG_MEM_CORRECTED_FLAG(ev[5]), .DIE_OVERHEAT_FLAG(ev[6]),
      .SLEEP_EN(slp), .TEMP_INPUT_ONE_OVER(ev[7]),
      .TEMP_INPUT_TWO_OVER(ev[8]), .THERMISTOR_ONE_POWER_EN(t1),
      .THERMISTOR_TWO_POWER_EN(t2), .OT_COMP_EN(ote), .BALANCE_OUTPUT(bal));
   psbc_host i_psbc_host (.REF_CLK(clk), .RESET_N(rst_n), .LNK(lnk),
      .S_AWADDR(aw_a), .S_AWVALID(aw_v), .S_AWREADY(aw_rdy),
      .S_WDATA(w_d), .S_WSTRB(4'hF), .S_WVALID(w_v), .S_WREADY(w_rdy),
      .S_BRESP(), .S_BVALID(b_v), .S_BREADY(b_r), .S_ARADDR(ar_a),
      .S_ARVALID(ar_v), .S_ARREADY(ar_rdy), .S_RDATA(r_d), .S_RRESP(),
      .S_RVALID(r_v), .S_RREADY(r_r));
   psbc_properties i_psbc_properties (.REF_CLK(clk), .RESET_N(rst_n),
      .HOST_SEL(hsel), .fault_h(lnk.fault_h), .alert_h(lnk.alert_h),
      .wr_fault(lnk.wr_fault), .wr_alert(lnk.wr_alert), .wdata(lnk.wdata),
      .fault_status(lnk.fault_status), .alert_status(lnk.alert_status),
      .dev_status(lnk.dev_status));
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task final_report;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task tmo;
      num_errors++;
      final_report;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      aw_a <= a;
      w_d <= v;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (aw_rdy) aw_v <= 1'b0;
         if (w_rdy) w_v <= 1'b0;
         if (b_v) break;
      end
      b_r <= 1'b0;
      if (i == 50) tmo;
      cyc(2);
   endtask
   task rd(input logic [7:0] a);
      int i;
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (ar_rdy) ar_v <= 1'b0;
         if (r_v) break;
      end
      d = r_d;
      r_r <= 1'b0;
      if (i == 50) tmo;
      @(posedge clk);
   endtask
   // Bounded wait for the timer to drop the balance outputs
   task rng(input int lo, input int hi);
      for (n = 0; n < 2000 && bal !== 6'h00; n++) @(posedge clk);
      if (n == 2000) tmo;
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask
   // ***************
   // Scenarios
   // ***************
   task s_reset;
      chk(32'({t1, t2}), 32'h0);
      cyc(2);
      rd(8'h14);
      chk(d, 32'h101);
      wr(8'h10, 32'h1);
      chk(32'({t1, t2}), 32'h2);
      wr(8'h10, 32'h3);
   endtask
   task s_events;
      for (int i = 0; i < 10; i++) begin
         ev <= 10'(1 << i);
         cyc(1);
         ev <= '0;
         rd(i < 4 ? 8'h00 : 8'h04);
         chk(d, 32'(1 << EVB[i]) | (i == 0 ? 32'h4 : 32'h0));
         rd(8'h14);
         chk(d, i < 4 ? (i == 1 ? 32'h1 : 32'h101) : 32'h202);
         wr(i < 4 ? 8'h00 : 8'h04, 32'(1 << EVB[i]) | 32'h4);
         rd(8'h14);
         chk(d, 32'h0);
      end
   endtask
   task s_sleep;
      slp <= 1'b1;
      cyc(3);
      chk(32'(ote), 32'h0);
      slp <= 1'b0;
      cyc(HOLD - 2);
      chk(32'(ote), 32'h0);
      cyc(6);
      chk(32'(ote), 32'h1);
      rd(8'h04);
      chk(d, 32'h20);
      wr(8'h04, 32'h20);
   endtask
   task s_chain;
      fn <= 1'b1;
      an <= 1'b1;
      cyc(2);
      rd(8'h14);
      chk(d | 32'({sf, sa}), 32'h300);
      hsel <= 1'b1;
      cyc(2);
      rd(8'h14);
      chk(d | 32'({sf, sa}), 32'h3);
      fn <= 1'b0;
      an <= 1'b0;
      wr(8'h00, 32'h2);
      chk(32'({sf, sa}), 32'h2);
      wr(8'h04, 32'h8);
      hsel <= 1'b0;
      wr(8'h00, 32'h6);
      rd(8'h14);
      chk(d | 32'({sf, sa}), 32'h303);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      rd(8'h04);
      chk(d, 32'h0);
   endtask
   task s_balance;
      wr(8'h0C, 32'hA);
      wr(8'h08, 32'h2);
      chk(32'(bal), 32'h2);
      rd(8'h14);
      chk(32'(d[2]), 32'h1);
      cyc(40);
      wr(8'h08, 32'h3);
      chk(32'(bal), 32'h3);
      rng(30, 70);
      wr(8'h08, 32'h1);
      cyc(40);
      wr(8'h08, 32'h0);
      chk(32'(bal), 32'h0);
      wr(8'h08, 32'h1);
      rng(80, 110);
      rd(8'h14);
      chk(32'(d[2]), 32'h0);
      wr(8'h0C, 32'h2);
      wr(8'h08, 32'h81);
      rng(500, 1250);
      wr(8'h0C, 32'h0);
      wr(8'h08, 32'h1);
      chk(32'(bal), 32'h0);
   endtask
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      s_reset;
      s_events;
      s_sleep;
      s_chain;
      s_balance;
      final_report;
   end
endmodule // tb
